/* File: inc/dcs_pkg.sv */
// package: register indices, field positions, reset values for the line access control block
package dcs_pkg;
  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_HOOK      = 6'h05;
  localparam logic [5:0] IDX_CTRL2     = 6'h06;
  localparam logic [5:0] IDX_RSVD7     = 6'h07;
  localparam logic [5:0] IDX_RSVD8     = 6'h08;
  localparam logic [5:0] IDX_RATE      = 6'h09;
  localparam logic [5:0] IDX_RSVD10    = 6'h0A;
  localparam logic [5:0] IDX_REV       = 6'h0B;
  localparam logic [5:0] IDX_LSTAT     = 6'h0C;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h10;
  localparam logic [5:0] IDX_IRQ_CLR   = 6'h11;
  localparam logic [5:0] IDX_IRQ_EN    = 6'h12;

  // output-level and power-down register layout
  localparam int         TXL_HI_BIT    = 6;
  localparam int         TXL_LO_BIT    = 1;
  localparam int         RXL_HI_BIT    = 5;
  localparam int         RXL_LO_BIT    = 0;
  localparam int         PDL_BIT       = 4;
  localparam int         PDN_BIT       = 3;
  localparam logic [7:0] CTRL2_WMASK   = 8'h73;
  localparam logic [7:0] CTRL2_RESET   = 8'h70;

  // sample rate
  localparam logic [2:0] RATE_RESET    = 3'h0;
  localparam logic [2:0] RATE_RSVD     = 3'h7;

  // line status layout
  localparam int         CLE_BIT       = 7;
  localparam int         FDT_BIT       = 6;

  // loop-current decode exceptions
  localparam logic [4:0] SENSE_HI_EXC  = 5'h1E;
  localparam logic [3:0] LCS_HI_EXC    = 4'hE;
  localparam logic [4:0] SENSE_LO_EXC  = 5'h01;
  localparam logic [3:0] LCS_LO_EXC    = 4'h1;

  // interrupt bits
  localparam int         IRQ_W         = 3;
  localparam int         IRQ_LINK_ERR  = 0;
  localparam int         IRQ_LOCK_ON   = 1;
  localparam int         IRQ_LOCK_OFF  = 2;

  // ahb
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam int         SYNC_STAGES   = 3;
endpackage : dcs_pkg

/* File: core/dcs_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module dcs_sync
  import dcs_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] out_nxt;

  if (WIDTH < 1) begin : g_chk
    $error("dcs_sync: WIDTH must be at least 1");
  end

  // a bit changes only once stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else if (ce_i) begin
      s1_r  <= async_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_o = out_r;
endmodule : dcs_sync

/* File: core/dcs_regs.sv */
// control and status register bank of the system-side line access module
//
// Contract
// - tx level field bits 6,1: 00 -26dB, 01 -20dB, 10 mute, 11 -32dB.
// - rx level field bits 5,0: 00 -6dB, 01 0dB, 10 mute, 11 -12dB.
// - line chip power-down bit 4 drives low power; clock setup precedes clearing.
// - system power-down bit 3 stays set until reset; clearing has no effect.
// - output-level and power-down register resets to 0111_0000.
// - three-bit sample rate code selects 7200 to 10286 Hz; 111 reserved.
// - revision register shows read-only four-bit value in bits 3:0.
// - link error flag bit 7 sets on link failure, clears on written zero.
// - frame lock flag bit 6 reads one while link frame lock holds.
// - off-hook loop current is sense 4:1, except 11110->1110, 00001->0001.
// - on-hook loop current is sense bits 4:1 without exception.
// - hook control bit selects decoding: 1 off-hook, 0 on-hook.
`timescale 1ns/1ns
module dcs_regs
  import dcs_pkg::*;
#(
  parameter logic [3:0] SYS_REVISION = 4'h1  // arbitrary value
) (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // line side status inputs, asynchronous
  input  wire logic [4:0]  line_sense_value_i,
  input  wire logic        frame_lock_i,
  input  wire logic        link_error_i,
  // controls
  output logic [1:0]       tx_monitor_level_o,
  output logic [1:0]       rx_monitor_level_o,
  output logic             line_chip_powerdown_o,
  output logic             system_powerdown_o,
  output logic [2:0]       sample_rate_code_o,
  output logic             hook_control_o,
  output logic             irq_o
);
  logic [4:0]       sense_s;
  logic             lock_s;
  logic             lerr_s;
  logic [7:0]       ctrl2_r;
  logic [7:0]       ctrl2_nxt;
  logic [2:0]       rate_r;
  logic [2:0]       rate_nxt;
  logic             hook_r;
  logic             hook_nxt;
  logic             cle_r;
  logic             cle_nxt;
  logic             lock_d_r;
  logic             lerr_d_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_stat_nxt;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_en_nxt;
  logic             wr_pend_r;
  logic             wr_pend_nxt;
  logic [5:0]       wr_idx_r;
  logic [5:0]       wr_idx_nxt;
  logic [31:0]      hrdata_r;
  logic [31:0]      hrdata_nxt;
  logic [3:0]       lcs;
  logic [7:0]       rd_byte;
  logic [7:0]       wbyte;
  logic             accept;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;

  dcs_sync #(.WIDTH(7)) u_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .async_i    ({link_error_i, frame_lock_i, line_sense_value_i}),
    .sync_o     ({lerr_s, lock_s, sense_s})
  );

  // loop current decode
  always_comb begin
    lcs = sense_s[4:1];
    if (hook_r) begin
      if (sense_s == SENSE_HI_EXC) begin
        lcs = LCS_HI_EXC;
      end else if (sense_s == SENSE_LO_EXC) begin
        lcs = LCS_LO_EXC;
      end
    end
  end

  // read mux
  always_comb begin
    rd_byte = 8'h00;
    if (haddr_i[7:2] == IDX_HOOK) begin
      rd_byte = {7'h00, hook_r};
    end else if (haddr_i[7:2] == IDX_CTRL2) begin
      rd_byte = ctrl2_r;
    end else if (haddr_i[7:2] == IDX_RATE) begin
      rd_byte = {5'h00, rate_r};
    end else if (haddr_i[7:2] == IDX_REV) begin
      rd_byte = {4'h0, SYS_REVISION};
    end else if (haddr_i[7:2] == IDX_LSTAT) begin
      rd_byte = {cle_r, lock_s, 2'h0, lcs};
    end else if (haddr_i[7:2] == IDX_IRQ_STAT) begin
      rd_byte = {5'h00, irq_stat_r};
    end else if (haddr_i[7:2] == IDX_IRQ_EN) begin
      rd_byte = {5'h00, irq_en_r};
    end
  end

  // bus phase tracking
  always_comb begin
    accept      = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
    wr_pend_nxt = accept && hwrite_i;
    wr_idx_nxt  = accept ? haddr_i[7:2] : wr_idx_r;
    hrdata_nxt  = (accept && !hwrite_i) ? {24'h000000, rd_byte} : hrdata_r;
  end

  // register updates
  always_comb begin
    wbyte     = hwdata_i[7:0];
    ctrl2_nxt = ctrl2_r;
    rate_nxt  = rate_r;
    hook_nxt  = hook_r;
    cle_nxt   = cle_r;
    irq_en_nxt = irq_en_r;
    clr       = '0;
    ev        = '0;
    if (wr_pend_r) begin
      if (wr_idx_r == IDX_HOOK) begin
        hook_nxt = wbyte[0];
      end else if (wr_idx_r == IDX_CTRL2) begin
        ctrl2_nxt = wbyte & CTRL2_WMASK;
        ctrl2_nxt[PDN_BIT] = ctrl2_r[PDN_BIT] | wbyte[PDN_BIT];
      end else if (wr_idx_r == IDX_RATE) begin
        if (wbyte[2:0] != RATE_RSVD) begin
          rate_nxt = wbyte[2:0];
        end
      end else if (wr_idx_r == IDX_LSTAT) begin
        if (!wbyte[CLE_BIT]) begin
          cle_nxt = 1'b0;
        end
      end else if (wr_idx_r == IDX_IRQ_CLR) begin
        clr = wbyte[IRQ_W-1:0];
      end else if (wr_idx_r == IDX_IRQ_EN) begin
        irq_en_nxt = wbyte[IRQ_W-1:0];
      end
    end
    ev[IRQ_LINK_ERR] = lerr_s && !lerr_d_r;
    ev[IRQ_LOCK_ON]  = lock_s && !lock_d_r;
    ev[IRQ_LOCK_OFF] = !lock_s && lock_d_r;
    if (lerr_s) begin
      cle_nxt = 1'b1;
    end
    irq_stat_nxt = (irq_stat_r & ~clr) | ev;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl2_r    <= CTRL2_RESET;
      rate_r     <= RATE_RESET;
      hook_r     <= 1'b0;
      cle_r      <= 1'b0;
      lock_d_r   <= 1'b0;
      lerr_d_r   <= 1'b0;
      irq_stat_r <= '0;
      irq_en_r   <= '0;
      wr_pend_r  <= 1'b0;
      wr_idx_r   <= 6'h00;
      hrdata_r   <= 32'h00000000;
    end else if (ce_i) begin
      ctrl2_r    <= ctrl2_nxt;
      rate_r     <= rate_nxt;
      hook_r     <= hook_nxt;
      cle_r      <= cle_nxt;
      lock_d_r   <= lock_s;
      lerr_d_r   <= lerr_s;
      irq_stat_r <= irq_stat_nxt;
      irq_en_r   <= irq_en_nxt;
      wr_pend_r  <= wr_pend_nxt;
      wr_idx_r   <= wr_idx_nxt;
      hrdata_r   <= hrdata_nxt;
    end
  end

  assign hreadyout_o           = 1'b1;
  assign hresp_o               = 1'b0;
  assign hrdata_o              = hrdata_r;
  assign tx_monitor_level_o    = {ctrl2_r[TXL_HI_BIT], ctrl2_r[TXL_LO_BIT]};
  assign rx_monitor_level_o    = {ctrl2_r[RXL_HI_BIT], ctrl2_r[RXL_LO_BIT]};
  assign line_chip_powerdown_o = ctrl2_r[PDL_BIT];
  assign system_powerdown_o    = ctrl2_r[PDN_BIT];
  assign sample_rate_code_o    = rate_r;
  assign hook_control_o        = hook_r;
  assign irq_o                 = |(irq_stat_r & irq_en_r);
endmodule : dcs_regs

/* File: tb/dcs_regs_properties.sv */
// checker: bus, reset and control properties of the register bank
`timescale 1ns/1ns
module dcs_regs_chk
  import dcs_pkg::*;
#(
  parameter logic [3:0] SYS_REVISION = 4'h1
) (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic        hreadyout_o,
  input  wire logic        hresp_o,
  input  wire logic [31:0] hrdata_o,
  input  wire logic [4:0]  line_sense_value_i,
  input  wire logic        frame_lock_i,
  input  wire logic        link_error_i,
  input  wire logic [1:0]  tx_monitor_level_o,
  input  wire logic [1:0]  rx_monitor_level_o,
  input  wire logic        line_chip_powerdown_o,
  input  wire logic        system_powerdown_o,
  input  wire logic [2:0]  sample_rate_code_o,
  input  wire logic        hook_control_o,
  input  wire logic        irq_o
);
  wire       rd_t     = hsel_i & hready_i & htrans_i[1] & !hwrite_i & ce_i;
  wire       wr_t     = hsel_i & hready_i & htrans_i[1] & hwrite_i & ce_i;
  wire [8:0] ctrl_bus = {tx_monitor_level_o, rx_monitor_level_o, line_chip_powerdown_o,
                         system_powerdown_o, sample_rate_code_o};
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rd(logic [5:0] idx);
    rd_t && haddr_i[7:2] == idx;
  endsequence
  sequence s_reset_out;
    tx_monitor_level_o == 2'b10 && rx_monitor_level_o == 2'b10 &&
      line_chip_powerdown_o && !system_powerdown_o;
  endsequence
  chk_bus_okay: assert property (hreadyout_o && !hresp_o && hrdata_o[31:8] == 24'h0)
    else $error("bus response or upper data wrong");
  chk_reset_levels: assert property ($rose(resetn_i) |-> s_reset_out)
    else $error("control reset values wrong");
  chk_pdn_sticky: assert property (system_powerdown_o |=> system_powerdown_o)
    else $error("system powerdown cleared without reset");
  chk_rate_legal: assert property (sample_rate_code_o != RATE_RSVD)
    else $error("reserved rate code taken");
  chk_ctrl_hold: assert property (!$past(wr_t, 2) |-> $stable(ctrl_bus))
    else $error("control changed without a write");
  chk_rsvd_zero: assert property ((s_rd(IDX_RSVD7) or s_rd(IDX_RSVD8) or s_rd(IDX_RSVD10))
    |=> hrdata_o == 32'h0) else $error("reserved register read nonzero");
  chk_rev_value: assert property (s_rd(IDX_REV) |=> hrdata_o == {28'h0, SYS_REVISION})
    else $error("revision readout wrong");
  chk_lstat_gap: assert property (s_rd(IDX_LSTAT) |=> hrdata_o[5:4] == 2'b00)
    else $error("status reserved bits nonzero");
  chk_rdata_hold: assert property (!rd_t |=> $stable(hrdata_o))
    else $error("read data moved without a read");
endmodule : dcs_regs_chk
bind dcs_regs dcs_regs_chk #(.SYS_REVISION(SYS_REVISION)) u_chk (.*);

/* File: tb/dcs_line_model.sv */
// line-side chip model: sense value, frame lock and link fault
`timescale 1ns/1ns
module dcs_line_model (
  input  wire logic       core_clk_i,
  input  wire logic       line_chip_powerdown_i,
  input  wire logic       link_fail_i,
  input  wire logic [4:0] sense_i,
  output logic      [4:0] line_sense_value_o,
  output logic            frame_lock_o,
  output logic            link_error_o
);
  always @(posedge core_clk_i) begin
    frame_lock_o       <= !line_chip_powerdown_i;
    link_error_o       <= link_fail_i;
    line_sense_value_o <= sense_i;
  end
endmodule : dcs_line_model

/* File: tb/tb_daa_control_status_regs.sv */
// testbench: register bank against a behavioural model
`timescale 1ns/1ns
module tb_daa_control_status_regs;
  import dcs_pkg::*;
  localparam logic [3:0] REV = 4'hA;  // arbitrary value
  logic clk = 0, rstn = 0, ce = 1, hsel = 0, hwrite = 0, hrdy, hresp, lfail = 0;
  logic lpd, spd, hook, lock, lerr, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, txl, rxl;
  logic [2:0] rate;
  logic [4:0] sense, scmd = 0;
  logic [7:0] ctrl, lc;
  int fail_count = 0, total_checks = 0, i, r;
  logic [5:0] rsv[4] = '{IDX_RSVD7, IDX_RSVD8, IDX_RSVD10, 6'h3F};
  always #5 clk = ~clk;
  dcs_regs #(.SYS_REVISION(REV)) dut (.core_clk_i(clk), .resetn_i(rstn), .ce_i(ce),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp),
    .hrdata_o(hrdata), .line_sense_value_i(sense), .frame_lock_i(lock), .link_error_i(lerr),
    .tx_monitor_level_o(txl), .rx_monitor_level_o(rxl), .line_chip_powerdown_o(lpd),
    .system_powerdown_o(spd), .sample_rate_code_o(rate), .hook_control_o(hook), .irq_o(irq));
  dcs_line_model u_line (.core_clk_i(clk), .line_chip_powerdown_i(lpd), .link_fail_i(lfail),
    .sense_i(scmd), .line_sense_value_o(sense), .frame_lock_o(lock), .link_error_o(lerr));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic xfer(input logic [5:0] idx, input logic w, input logic [7:0] v);
    hsel   <= 1'b1;
    haddr  <= {24'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    do @(posedge clk); while (hrdy !== 1'b1);
  endtask : xfer
  task automatic rc(input logic [5:0] idx, input logic [7:0] e);
    xfer(idx, 0, 8'h00);
    chk($sformatf("reg %0h", idx), e, hrdata[7:0]);
  endtask : rc
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  initial begin
    #50000;
    fail_count++;
    $display("FAIL watchdog expected done seen timeout");
    summarize();
  end
  initial begin
    r = $urandom(32'he382);
    repeat (6) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rc(IDX_CTRL2, 8'h70);
    chk("lpd", 8'h01, {7'h0, lpd});
    rc(IDX_RATE, 8'h00);
    xfer(IDX_REV, 1, 8'hFF);
    rc(IDX_REV, {4'h0, REV});
    foreach (rsv[k]) begin
      xfer(rsv[k], 1, 8'hFF);
      rc(rsv[k], 8'h00);
    end
    for (i = 0; i < 16; i++) begin
      ctrl = (8'($urandom) & 8'h94) | {1'b0, i[3], i[1], 3'b000, i[2], i[0]};
      xfer(IDX_CTRL2, 1, ctrl);
      ctrl = ctrl & CTRL2_WMASK;
      rc(IDX_CTRL2, ctrl);
      chk("levels", {4'h0, ctrl[6], ctrl[1], ctrl[5], ctrl[0]}, {4'h0, txl, rxl});
      chk("lpd", {7'h0, ctrl[4]}, {7'h0, lpd});
    end
    r = 0;
    for (i = 0; i < 8; i++) begin
      xfer(IDX_RATE, 1, (8'($urandom) & 8'hF8) | {5'h0, i[2:0]});
      if (i != 7) r = i;
      rc(IDX_RATE, r[7:0]);
      chk("rate", r[7:0], {5'h0, rate});
    end
    xfer(IDX_CTRL2, 1, 8'h00);
    for (i = 0; i < 24; i++) begin
      scmd <= i < 2 ? 5'h1E : i < 4 ? 5'h01 : 5'($urandom);
      xfer(IDX_HOOK, 1, {7'h0, i[0]});
      repeat (8) @(posedge clk);
      lc = {4'h0, sense[4:1]};
      if (i[0] && sense == SENSE_HI_EXC) lc = {4'h0, LCS_HI_EXC};
      if (i[0] && sense == SENSE_LO_EXC) lc = {4'h0, LCS_LO_EXC};
      rc(IDX_LSTAT, 8'h40 | lc);
      chk("hook", {7'h0, i[0]}, {7'h0, hook});
    end
    lfail <= 1;
    repeat (8) @(posedge clk);
    lfail <= 0;
    repeat (8) @(posedge clk);
    xfer(IDX_LSTAT, 1, 8'h80);
    rc(IDX_LSTAT, 8'hC0 | lc);
    xfer(IDX_LSTAT, 1, 8'h00);
    rc(IDX_LSTAT, 8'h40 | lc);
    xfer(IDX_CTRL2, 1, 8'h10);
    repeat (8) @(posedge clk);
    rc(IDX_LSTAT, lc);
    rc(IDX_IRQ_STAT, 8'h07);
    chk("irq", 8'h00, {7'h0, irq});
    xfer(IDX_IRQ_EN, 1, 8'h01);
    rc(IDX_IRQ_EN, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    xfer(IDX_IRQ_CLR, 1, 8'h07);
    rc(IDX_IRQ_STAT, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    xfer(IDX_CTRL2, 1, 8'h00);
    repeat (8) @(posedge clk);
    rc(IDX_IRQ_STAT, 8'h02);
    chk("irq", 8'h00, {7'h0, irq});
    xfer(IDX_IRQ_EN, 1, 8'h02);
    rc(IDX_IRQ_STAT, 8'h02);
    chk("irq", 8'h01, {7'h0, irq});
    ce <= 1'b0;
    xfer(IDX_RATE, 1, 8'h03);
    ce <= 1'b1;
    rc(IDX_RATE, 8'h06);
    chk("rate", 8'h06, {5'h0, rate});
    xfer(IDX_CTRL2, 1, 8'h08);
    xfer(IDX_CTRL2, 1, 8'h00);
    rc(IDX_CTRL2, 8'h08);
    chk("spd", 8'h01, {7'h0, spd});
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rc(IDX_CTRL2, 8'h70);
    chk("spd", 8'h00, {7'h0, spd});
    summarize();
  end
endmodule : tb_daa_control_status_regs
